// *** rtl/prp_pkg.sv ***
package prp_pkg;
    localparam int GRP_W    = 10;
    localparam int GRP_N    = 3;
    localparam int BUS_W    = GRP_W * GRP_N;
    localparam int COL_W    = 8;
    localparam int COL_LSB  = GRP_W - COL_W;
    localparam int PIX_W    = COL_W * GRP_N;
    localparam int WORD_W   = PIX_W + 2;
    localparam int FIFO_DEPTH = 32;
    localparam int RED_LSB  = 2 * COL_W;
    localparam int GRN_LSB  = COL_W;
    localparam int BLU_LSB  = 0;
    localparam int SOF_BIT  = PIX_W + 1;
    localparam int SOL_BIT  = PIX_W;

    typedef logic [1:0] prp_grp_sel_t;
    localparam prp_grp_sel_t GRP_A    = 2'h0;
    localparam prp_grp_sel_t GRP_B    = 2'h1;
    localparam prp_grp_sel_t GRP_C    = 2'h2;
    localparam prp_grp_sel_t GRP_NONE = 2'h3;
endpackage

// *** rtl/prp_rx.sv ***
`timescale 1ns/1ps
`default_nettype none

module prp_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wptr_reg;
    logic [AW:0]      rptr_reg;
    logic             push;
    logic             pop;

    assign out_valid_o = (wptr_reg != rptr_reg);
    assign in_ready_o  = (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]) || (wptr_reg[AW] == rptr_reg[AW]);
    assign out_data_o  = mem_reg[rptr_reg[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_reg[wptr_reg[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_reg + (AW+1)'(push);
            rptr_reg <= rptr_reg + (AW+1)'(pop);
        end
    end
endmodule

module prp_port (
    input  wire logic                         clk_sys_i,
    input  wire logic                         rstn_i,
    input  wire logic                         pclk_sync_i,
    input  wire logic [prp_pkg::BUS_W-1:0]    pixel_bus_i,
    input  wire logic                         frame_sync_i,
    input  wire logic                         line_sync_i,
    input  wire logic                         pixel_valid_i,
    input  wire prp_pkg::prp_grp_sel_t        red_sel_i,
    input  wire prp_pkg::prp_grp_sel_t        grn_sel_i,
    input  wire prp_pkg::prp_grp_sel_t        blu_sel_i,
    output logic [prp_pkg::PIX_W-1:0]         pix_data_o,
    output logic                              pix_sof_o,
    output logic                              pix_sol_o,
    output logic                              pix_valid_o,
    input  wire logic                         pix_ready_i,
    output logic                              frame_tick_o,
    output logic                              frame_repeat_o,
    output logic                              overflow_o
);
    import prp_pkg::*;

    // upper eight lines of the selected ten-bit group
    function automatic logic [COL_W-1:0] pick_colour(input logic [BUS_W-1:0] bus,
                                                     input prp_grp_sel_t     sel);
        case (sel)
            GRP_A:   return bus[0*GRP_W+COL_LSB +: COL_W];
            GRP_B:   return bus[1*GRP_W+COL_LSB +: COL_W];
            GRP_C:   return bus[2*GRP_W+COL_LSB +: COL_W];
            default: return '0;
        endcase
    endfunction
    logic [BUS_W-1:0]  bus_s1_reg;
    logic [BUS_W-1:0]  bus_s2_reg;
    logic [2:0]        ctl_s1_reg;
    logic [2:0]        ctl_s2_reg;
    logic              pclk_d_reg;
    logic              fs_d_reg;
    logic              ls_d_reg;
    logic              sof_pend_reg;
    logic              sol_pend_reg;
    logic              seen_reg;
    logic              pclk_rise;
    logic              frame_edge;
    logic              line_edge;
    logic              wr_valid;
    logic              wr_ready;
    logic [WORD_W-1:0] wr_word;
    logic [WORD_W-1:0] rd_word;
    logic              rd_valid;
    logic              rd_ready;

    // ctl bits: 2 frame sync, 1 line sync, 0 valid; the source is asynchronous to clk_sys
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_s1_reg <= '0;
            bus_s2_reg <= '0;
            ctl_s1_reg <= '0;
            ctl_s2_reg <= '0;
        end else begin
            bus_s1_reg <= pixel_bus_i;
            bus_s2_reg <= bus_s1_reg;
            ctl_s1_reg <= {frame_sync_i, line_sync_i, pixel_valid_i};
            ctl_s2_reg <= ctl_s1_reg;
        end
    end

    assign pclk_rise  = pclk_sync_i && !pclk_d_reg;
    assign frame_edge = pclk_rise && ctl_s2_reg[2] && !fs_d_reg;
    assign line_edge  = pclk_rise && ctl_s2_reg[1] && !ls_d_reg;
    assign wr_valid   = pclk_rise && ctl_s2_reg[0];
    assign wr_word[RED_LSB +: COL_W] = pick_colour(bus_s2_reg, red_sel_i);
    assign wr_word[GRN_LSB +: COL_W] = pick_colour(bus_s2_reg, grn_sel_i);
    assign wr_word[BLU_LSB +: COL_W] = pick_colour(bus_s2_reg, blu_sel_i);
    assign wr_word[SOF_BIT] = sof_pend_reg || frame_edge;
    assign wr_word[SOL_BIT] = sol_pend_reg || line_edge;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pclk_d_reg <= 1'b0;
            fs_d_reg   <= 1'b0;
            ls_d_reg   <= 1'b0;
        end else begin
            pclk_d_reg <= pclk_sync_i;
            if (pclk_rise) begin
                fs_d_reg <= ctl_s2_reg[2];
                ls_d_reg <= ctl_s2_reg[1];
            end
        end
    end
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sof_pend_reg <= 1'b0;
            sol_pend_reg <= 1'b0;
        end else begin
            sof_pend_reg <= !wr_valid && (sof_pend_reg || frame_edge);
            sol_pend_reg <= !wr_valid && (sol_pend_reg || line_edge);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seen_reg       <= 1'b0;
            frame_tick_o   <= 1'b0;
            frame_repeat_o <= 1'b0;
        end else begin
            frame_tick_o <= frame_edge;
            if (frame_edge) begin
                frame_repeat_o <= !seen_reg;
                seen_reg       <= wr_valid;
            end else if (wr_valid) begin
                seen_reg <= 1'b1;
            end
        end
    end

    // source cannot stall, so a pixel meeting a full fifo is dropped and flagged
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            overflow_o <= 1'b0;
        end else begin
            overflow_o <= (wr_valid && !wr_ready) || (overflow_o && !frame_edge);
        end
    end

    prp_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rstn_i      (rstn_i),
        .in_data_i   (wr_word),
        .in_valid_i  (wr_valid),
        .in_ready_o  (wr_ready),
        .out_data_o  (rd_word),
        .out_valid_o (rd_valid),
        .out_ready_i (rd_ready)
    );

    // output register keeps every output on a flop
    assign rd_ready = !pix_valid_o || pix_ready_i;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pix_valid_o <= 1'b0;
            pix_data_o  <= '0;
            pix_sof_o   <= 1'b0;
            pix_sol_o   <= 1'b0;
        end else if (rd_ready) begin
            pix_valid_o <= rd_valid;
            pix_data_o  <= rd_word[PIX_W-1:0];
            pix_sof_o   <= rd_word[SOF_BIT];
            pix_sol_o   <= rd_word[SOL_BIT];
        end
    end
endmodule

module prp_rx (
    input  wire logic                         clk_sys_i,
    input  wire logic                         rstn_i,
    input  wire logic                         port_one_pixel_clock_i,
    input  wire logic                         port_two_pixel_clock_i,
    input  wire logic                         spare_pixel_clock_i,
    input  wire logic [prp_pkg::BUS_W-1:0]    port_one_pixel_bus_i,
    input  wire logic                         port_one_frame_sync_i,
    input  wire logic                         port_one_line_sync_i,
    input  wire logic                         port_one_pixel_valid_i,
    input  wire logic [prp_pkg::BUS_W-1:0]    port_two_pixel_bus_i,
    input  wire logic                         port_two_frame_sync_i,
    input  wire logic                         port_two_line_sync_i,
    input  wire logic                         port_two_pixel_valid_i,
    input  wire logic [1:0]                   use_spare_clock_i,
    input  wire prp_pkg::prp_grp_sel_t        red_sel_i [2],
    input  wire prp_pkg::prp_grp_sel_t        grn_sel_i [2],
    input  wire prp_pkg::prp_grp_sel_t        blu_sel_i [2],
    output logic [prp_pkg::PIX_W-1:0]         pix_data_o [2],
    output logic [1:0]                        pix_sof_o,
    output logic [1:0]                        pix_sol_o,
    output logic [1:0]                        pix_valid_o,
    input  wire logic [1:0]                   pix_ready_i,
    output logic [1:0]                        frame_tick_o,
    output logic [1:0]                        frame_repeat_o,
    output logic [1:0]                        overflow_o
);
    import prp_pkg::*;
    logic [2:0] clk_s1_reg;
    logic [2:0] clk_s2_reg;
    logic [1:0] pclk_sel;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clk_s1_reg <= '0;
            clk_s2_reg <= '0;
        end else begin
            clk_s1_reg <= {spare_pixel_clock_i, port_two_pixel_clock_i, port_one_pixel_clock_i};
            clk_s2_reg <= clk_s1_reg;
        end
    end

    assign pclk_sel[0] = use_spare_clock_i[0] ? clk_s2_reg[2] : clk_s2_reg[0];
    assign pclk_sel[1] = use_spare_clock_i[1] ? clk_s2_reg[2] : clk_s2_reg[1];

    prp_port u_port_one (
        .clk_sys_i      (clk_sys_i),
        .rstn_i         (rstn_i),
        .pclk_sync_i    (pclk_sel[0]),
        .pixel_bus_i    (port_one_pixel_bus_i),
        .frame_sync_i   (port_one_frame_sync_i),
        .line_sync_i    (port_one_line_sync_i),
        .pixel_valid_i  (port_one_pixel_valid_i),
        .red_sel_i      (red_sel_i[0]),
        .grn_sel_i      (grn_sel_i[0]),
        .blu_sel_i      (blu_sel_i[0]),
        .pix_data_o     (pix_data_o[0]),
        .pix_sof_o      (pix_sof_o[0]),
        .pix_sol_o      (pix_sol_o[0]),
        .pix_valid_o    (pix_valid_o[0]),
        .pix_ready_i    (pix_ready_i[0]),
        .frame_tick_o   (frame_tick_o[0]),
        .frame_repeat_o (frame_repeat_o[0]),
        .overflow_o     (overflow_o[0])
    );

    prp_port u_port_two (
        .clk_sys_i      (clk_sys_i),
        .rstn_i         (rstn_i),
        .pclk_sync_i    (pclk_sel[1]),
        .pixel_bus_i    (port_two_pixel_bus_i),
        .frame_sync_i   (port_two_frame_sync_i),
        .line_sync_i    (port_two_line_sync_i),
        .pixel_valid_i  (port_two_pixel_valid_i),
        .red_sel_i      (red_sel_i[1]),
        .grn_sel_i      (grn_sel_i[1]),
        .blu_sel_i      (blu_sel_i[1]),
        .pix_data_o     (pix_data_o[1]),
        .pix_sof_o      (pix_sof_o[1]),
        .pix_sol_o      (pix_sol_o[1]),
        .pix_valid_o    (pix_valid_o[1]),
        .pix_ready_i    (pix_ready_i[1]),
        .frame_tick_o   (frame_tick_o[1]),
        .frame_repeat_o (frame_repeat_o[1]),
        .overflow_o     (overflow_o[1])
    );
endmodule

`default_nettype wire

// *** dv/prp_rx_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module prp_rx_properties
    import prp_pkg::*;
(
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    input  wire logic               port_one_pixel_clock_i,
    input  wire logic               port_two_pixel_clock_i,
    input  wire logic               spare_pixel_clock_i,
    input  wire logic [BUS_W-1:0]   port_one_pixel_bus_i,
    input  wire logic               port_one_pixel_valid_i,
    input  wire logic               port_two_pixel_valid_i,
    input  wire logic [1:0]         use_spare_clock_i,
    input  wire prp_grp_sel_t       red_sel_i [2],
    input  wire logic [PIX_W-1:0]   pix_data_o [2],
    input  wire logic [1:0]         pix_valid_o,
    input  wire logic [1:0]         pix_ready_i,
    input  wire logic [1:0]         frame_tick_o,
    input  wire logic [1:0]         frame_repeat_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_take0;
        $rose(port_one_pixel_clock_i) && port_one_pixel_valid_i
            && !use_spare_clock_i[0] && !pix_valid_o[0];
    endsequence
    sequence s_take1;
        $rose(port_two_pixel_clock_i) && port_two_pixel_valid_i
            && !use_spare_clock_i[1] && !pix_valid_o[1];
    endsequence
    sequence s_spare1;
        $rose(spare_pixel_clock_i) && port_two_pixel_valid_i
            && use_spare_clock_i[1] && !pix_valid_o[1];
    endsequence

    property p_lat0; s_take0 |-> ##[2:6] pix_valid_o[0]; endproperty
    property p_lat1; s_take1 |-> ##[2:6] pix_valid_o[1]; endproperty
    property p_spare1; s_spare1 |-> ##[2:6] pix_valid_o[1]; endproperty
    property p_hold0;
        pix_valid_o[0] && !pix_ready_i[0] |=> pix_valid_o[0] && $stable(pix_data_o[0]);
    endproperty
    property p_hold1;
        pix_valid_o[1] && !pix_ready_i[1] |=> pix_valid_o[1] && $stable(pix_data_o[1]);
    endproperty
    property p_tick0; frame_tick_o[0] |=> !frame_tick_o[0]; endproperty
    property p_rpt0; $changed(frame_repeat_o[0]) |-> frame_tick_o[0]; endproperty
    // red from group c: bus sampled while the source held it
    property p_map0;
        $rose(pix_valid_o[0]) && red_sel_i[0] == GRP_C |->
            pix_data_o[0][RED_LSB +: COL_W] == $past(port_one_pixel_bus_i[29:22], 3);
    endproperty

    a_lat0: assert property (p_lat0) else $error("port one pixel not delivered");
    a_lat1: assert property (p_lat1) else $error("port two pixel not delivered");
    a_spare1: assert property (p_spare1) else $error("spare clock capture missing");
    a_hold0: assert property (p_hold0) else $error("port one word dropped");
    a_hold1: assert property (p_hold1) else $error("port two word dropped");
    a_tick0: assert property (p_tick0) else $error("frame tick too long");
    a_rpt0: assert property (p_rpt0) else $error("repeat flag moved off tick");
    a_map0: assert property (p_map0) else $error("red byte wrong");
endmodule

bind prp_rx prp_rx_properties i_prp_rx_properties (
    .clk_sys_i, .rstn_i, .port_one_pixel_clock_i, .port_two_pixel_clock_i,
    .spare_pixel_clock_i, .port_one_pixel_bus_i, .port_one_pixel_valid_i,
    .port_two_pixel_valid_i, .use_spare_clock_i, .red_sel_i, .pix_data_o,
    .pix_valid_o, .pix_ready_i, .frame_tick_o, .frame_repeat_o
);
`default_nettype wire

// *** dv/prp_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module prp_src_model (
    input  wire logic    clk_i,
    output logic         pclk_o,
    output logic [29:0]  bus_o,
    output logic         fs_o,
    output logic         ls_o,
    output logic         dv_o
);
    initial begin
        pclk_o = 1'b0;
        bus_o = 30'h0;
        {fs_o, ls_o, dv_o} = 3'h0;
    end
    // colour on upper lines
    // callers start on a falling edge, so back-to-back pixels give an eight-cycle period
    task automatic pix(input logic f, input logic l, input logic v, input logic [23:0] w);
        {fs_o, ls_o, dv_o} = {f, l, v};
        // idle data flips so stale values never look valid
        bus_o = v ? {w[23:16], 2'h0, w[15:8], 2'h0, w[7:0], 2'h0} : ~bus_o;
        repeat (4) @(negedge clk_i);
        pclk_o = 1'b1;
        repeat (4) @(negedge clk_i);
        pclk_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import prp_pkg::*;
    localparam logic [23:0] W = 24'hC35A17;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               c1, c2, f1, f2, l1, l2, v1, v2;
    logic [BUS_W-1:0]   b1, b2;
    logic [1:0]         us = 2'h0;
    logic [1:0]         rdy = 2'h3;
    prp_grp_sel_t       rs [2] = '{GRP_C, GRP_C};
    prp_grp_sel_t       gs [2] = '{GRP_B, GRP_B};
    prp_grp_sel_t       bs [2] = '{GRP_A, GRP_A};
    logic [PIX_W-1:0]   pd [2];
    logic [1:0]         sof, sol, pv, tk, rp, ov;
    logic [23:0]        w0, w1;
    logic               s0, e0, r0, s1, e1, r1;
    int                 n0 = 0, n1 = 0, nt = 0, nt1 = 0, fail_count = 0, cmp_count = 0;

    always #12.5 clk = ~clk;

    prp_src_model u_src1 (.clk_i(clk), .pclk_o(c1), .bus_o(b1), .fs_o(f1), .ls_o(l1), .dv_o(v1));
    prp_src_model u_src2 (.clk_i(clk), .pclk_o(c2), .bus_o(b2), .fs_o(f2), .ls_o(l2), .dv_o(v2));

    prp_rx i_prp_rx (.clk_sys_i(clk), .rstn_i(rstn), .port_one_pixel_clock_i(c1 & ~us[0]),
        .port_two_pixel_clock_i(c2 & ~us[1]),
        .spare_pixel_clock_i((c1 & us[0]) | (c2 & us[1])),
        .port_one_pixel_bus_i(b1), .port_one_frame_sync_i(f1), .port_one_line_sync_i(l1),
        .port_one_pixel_valid_i(v1), .port_two_pixel_bus_i(b2), .port_two_frame_sync_i(f2),
        .port_two_line_sync_i(l2), .port_two_pixel_valid_i(v2), .use_spare_clock_i(us),
        .red_sel_i(rs), .grn_sel_i(gs), .blu_sel_i(bs), .pix_data_o(pd), .pix_sof_o(sof),
        .pix_sol_o(sol), .pix_valid_o(pv), .pix_ready_i(rdy), .frame_tick_o(tk),
        .frame_repeat_o(rp), .overflow_o(ov));

    always @(posedge clk) begin
        if (pv[0] && rdy[0]) begin
            n0 <= n0 + 1;
            {w0, s0, e0} <= {pd[0], sof[0], sol[0]};
        end
        if (pv[1] && rdy[1]) begin
            n1 <= n1 + 1;
            {w1, s1, e1} <= {pd[1], sof[1], sol[1]};
        end
        if (tk[0]) begin
            nt <= nt + 1;
            r0 <= rp[0];
        end
        if (tk[1]) begin
            nt1 <= nt1 + 1;
            r1 <= rp[1];
        end
    end

    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic wn(input int p, input int n);
        repeat (30) if ((p ? n1 : n0) <= n) @(negedge clk);
    endtask

    function automatic logic [7:0] g(input prp_grp_sel_t s);
        return s == GRP_A ? W[7:0] : s == GRP_B ? W[15:8] : s == GRP_C ? W[23:16] : 8'h00;
    endfunction

    task automatic t_map;
        logic [5:0] tab [4] = '{6'h24, 6'h06, 6'h18, 6'h31};
        int n;
        u_src1.pix(1'b1, 1'b1, 1'b0, W);
        for (int k = 0; k < 4; k++) begin
            {rs[0], gs[0], bs[0]} = tab[k];
            n = n0;
            u_src1.pix(k == 0, k == 0, 1'b1, W);
            wn(0, n);
            chk(n0 === n + 1 && w0 === {g(rs[0]), g(gs[0]), g(bs[0])}, "colour map");
            chk(s0 === (k == 0) && e0 === (k == 0), "start flags");
        end
        n = n0;
        u_src1.pix(1'b0, 1'b0, 1'b0, W);
        // latency is four cycles, twelve is ample
        repeat (12) @(negedge clk);
        chk(n0 === n, "stored without valid");
        $display("map test done");
    endtask

    task automatic t_spare;
        int n;
        for (int k = 1; k >= 0; k--) begin
            us[1] = k[0];
            n = n1;
            u_src2.pix(k == 1, k == 1, 1'b1, W);
            wn(1, n);
            chk(n1 === n + 1 && w1 === W, "port two capture");
            chk(s1 === (k == 1) && e1 === (k == 1), "port two start flags");
        end
        chk(nt1 === 1 && r1 === 1'b1 && ov[1] === 1'b0, "port two frame");
        us[0] = 1'b1;
        n = n0;
        u_src1.pix(1'b0, 1'b0, 1'b1, W);
        wn(0, n);
        chk(n0 === n + 1 && w0 === {g(rs[0]), g(gs[0]), g(bs[0])}, "port one spare");
        us[0] = 1'b0;
        $display("spare test done");
    endtask

    task automatic t_ovf;
        int n;
        rdy[0] = 1'b0;
        repeat (40) u_src1.pix(1'b0, 1'b0, 1'b1, W);
        chk(ov[0] === 1'b1, "no overflow");
        // a drop in the clearing frame edge keeps the flag
        u_src1.pix(1'b1, 1'b0, 1'b1, W);
        chk(ov[0] === 1'b1, "clear beat a drop");
        n = n0;
        rdy[0] = 1'b1;
        repeat (40) @(negedge clk);
        // one word in the output register plus a full fifo
        chk(n0 - n === 33, "drain count");
        u_src1.pix(1'b0, 1'b0, 1'b0, W);
        u_src1.pix(1'b1, 1'b0, 1'b0, W);
        chk(ov[0] === 1'b0, "overflow kept");
        $display("overflow test done");
    endtask

    task automatic t_rpt;
        int t;
        t = nt;
        // syncs keep coming on empty frames
        u_src1.pix(1'b0, 1'b0, 1'b1, W);
        u_src1.pix(1'b1, 1'b0, 1'b0, W);
        u_src1.pix(1'b0, 1'b0, 1'b0, W);
        chk(nt === t + 1 && r0 === 1'b0, "fresh frame");
        u_src1.pix(1'b1, 1'b0, 1'b0, W);
        u_src1.pix(1'b0, 1'b0, 1'b0, W);
        chk(nt === t + 2 && r0 === 1'b1, "repeat frame");
        $display("repeat test done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_map;
        t_spare;
        t_ovf;
        t_rpt;
        print_verdict;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        print_verdict;
    end
endmodule
`default_nettype wire
